// ---- ffs_pkg.sv ----
// Purpose: Shared constants for the frontend status flag block.
// Assumes: Core clock of 200 MHz.
// Notes:   Register addresses are byte addresses on the host register port.
package ffs_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam logic [5:0]  ADDR_STATUS1     = 6'h07;
    localparam logic [5:0]  ADDR_STATUS2     = 6'h08;
    localparam logic [7:0]  STATUS2_RESET    = 8'h00;
    // Status1 field positions.
    localparam int unsigned S1_FREQ_OK       = 7;
    localparam int unsigned S1_CRC_ZERO      = 6;
    localparam int unsigned S1_CRC_DONE      = 5;
    localparam int unsigned S1_IRQ           = 4;
    localparam int unsigned S1_TIMER         = 3;
    localparam int unsigned S1_FIELD         = 2;
    localparam int unsigned S1_NEAR_FULL     = 1;
    localparam int unsigned S1_NEAR_EMPTY    = 0;
    // Status2 field positions.
    localparam int unsigned S2_OVERHEAT_CLR  = 7;
    localparam int unsigned S2_I2C_FAST      = 6;
    localparam int unsigned S2_TARGET        = 4;
    localparam int unsigned S2_CIPHER        = 3;
    // FIFO geometry.
    localparam int unsigned FIFO_DEPTH       = 64;
    // Frequency window and limits.
    localparam int unsigned FREQ_WINDOW_NS   = 10000;
    localparam int unsigned FREQ_WINDOW_CYC  = FREQ_WINDOW_NS * CLK_MHZ / 1000;
    localparam int unsigned FREQ_LO_MHZ      = 12;
    localparam int unsigned FREQ_HI_MHZ      = 15;
    localparam int unsigned FREQ_LO_EDGES    = FREQ_LO_MHZ * FREQ_WINDOW_NS / 1000;
    localparam int unsigned FREQ_HI_EDGES    = FREQ_HI_MHZ * FREQ_WINDOW_NS / 1000;
    localparam int unsigned TEMP_LIMIT_DEGC  = 125;

    typedef enum logic [2:0] {
        MODEM_IDLE,
        MODEM_WAIT_TRIGGER,
        MODEM_TX_WAIT,
        MODEM_SENDING,
        MODEM_RX_WAIT,
        MODEM_WAIT_DATA,
        MODEM_RECEIVING
    } ffs_modem_e;
endpackage

// ---- ffs_freq_if.sv ----
// Purpose: Carrier between the status core and the frequency meter.
// Assumes: Single clock domain.
// Notes:   The meter samples the receive level and returns the range flag.
`timescale 1ns/1ps
interface ffs_freq_if;
    logic rxLevel;
    logic inRange;
    modport meter (input rxLevel, output inRange);
    modport core  (output rxLevel, input inRange);
endinterface

// ---- ffs_freq_meter.sv ----
// Purpose: Measures the receive input frequency over a fixed window.
// Assumes: Receive input is synchronous to clk.
// Notes:   Flag updates once per window; it is low after reset.
`timescale 1ns/1ps
module ffs_freq_meter (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Link to core.
    ffs_freq_if.meter fq
);
    localparam int unsigned CW = $clog2(ffs_pkg::FREQ_WINDOW_CYC + 1);

    logic [CW-1:0] winCnt_q;
    logic [CW-1:0] edgeCnt_q;
    logic          rxPrev_q;
    logic          inRange_q;
    logic          winEnd;
    logic          rise;

    assign winEnd = (winCnt_q == CW'(ffs_pkg::FREQ_WINDOW_CYC - 1));
    assign rise   = fq.rxLevel & ~rxPrev_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            winCnt_q <= '0;
        end else if (winEnd) begin
            winCnt_q <= '0;
        end else begin
            winCnt_q <= winCnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxPrev_q  <= 1'b0;
            edgeCnt_q <= '0;
        end else begin
            rxPrev_q  <= fq.rxLevel;
            if (winEnd) begin
                edgeCnt_q <= '0;
            end else if (rise) begin
                edgeCnt_q <= edgeCnt_q + CW'(1);
            end
        end
    end

    // Strictly inside the band; the edge bands outside it are don't-care.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            inRange_q <= 1'b0;
        end else if (winEnd) begin
            inRange_q <= (edgeCnt_q > CW'(ffs_pkg::FREQ_LO_EDGES))
                       && (edgeCnt_q < CW'(ffs_pkg::FREQ_HI_EDGES));
        end
    end

    assign fq.inRange = inRange_q;
endmodule

// ---- ffs_status_flags.sv ----
// Purpose: Two host status registers gathering frontend conditions.
// Assumes: All inputs synchronous to clk; event inputs are one-cycle pulses.
// Notes:   Read data is registered and appears one cycle after regRdEn.
`timescale 1ns/1ps
// Overview of operation
// - Frequency flag when 12 < f < 15 MHz.
// - Flag undefined in 9-12 and 15-19 MHz.
// - CRC-zero low while busy, follows result.
// - CRC-done set when computation finishes.
// - Interrupt bit: any enabled source requesting.
// - Timer flag while timer counts.
// - Gated mode: flag follows enable, ignores gate.
// - Field flag mirrors detector, no latching.
// - Near-full when 64 minus fill <= threshold.
// - Near-empty when fill <= threshold.
// - Status2 field layout, bit 5 reads zero.
// - Status2 resets to all zeros.
// - Modem state three-bit encoding.
// - Overheat clear works only below 125 C.
module ffs_status_flags #(
    parameter int unsigned COMM_IRQ_W = 7,
    parameter int unsigned DIV_IRQ_W  = 5
) (
    // Clock and reset.
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Host register port.
    input  wire logic [5:0]            regAddr,
    input  wire logic                  regWrEn,
    input  wire logic                  regRdEn,
    input  wire logic [7:0]            regWrData,
    output      logic [7:0]            regRdData,
    // RF front.
    input  wire logic                  rxLevel,
    input  wire logic                  fieldDetect,
    // CRC co-processor.
    input  wire logic                  crcStart,
    input  wire logic                  crcBusy,
    input  wire logic                  crcFinish,
    input  wire logic                  crcResultZero,
    // Interrupt aggregator.
    input  wire logic [COMM_IRQ_W-1:0] commIrqReq,
    input  wire logic [COMM_IRQ_W-1:0] commIrqEnable,
    input  wire logic [DIV_IRQ_W-1:0]  divIrqReq,
    input  wire logic [DIV_IRQ_W-1:0]  divIrqEnable,
    // Timer unit.
    input  wire logic                  timerCounting,
    input  wire logic                  timerEnabled,
    input  wire logic                  timerGatedMode,
    // FIFO.
    input  wire logic [6:0]            fifoFillCount,
    input  wire logic [5:0]            fifoThreshold,
    // Temperature and session events.
    input  wire logic                  overheatDetect,
    input  wire logic                  tempBelowLimit,
    input  wire logic                  targetSelectEvt,
    input  wire logic                  cipherStartEvt,
    input  wire logic [2:0]            modemState,
    // Controls and status out.
    output      logic                  tempError,
    output      logic                  i2cFilterForceFast,
    output      logic                  targetSelected,
    output      logic                  cipherSessionOn
);
    ffs_freq_if fq ();

    logic       crcZero_q;
    logic       crcDone_q;
    logic       irq_q;
    logic       timerActive_q;
    logic       fieldPresent_q;
    logic       fieldPrev_q;
    logic       nearFull_q;
    logic       nearEmpty_q;
    logic       overheatClr_q;
    logic       i2cFast_q;
    logic       target_q;
    logic       cipher_q;
    logic [2:0] modem_q;
    logic       tempErr_q;
    logic [7:0] rdData_q;
    logic [7:0] status1;
    logic [7:0] status2;
    logic       wrStatus2;
    logic [7:0] freeSpace;

    assign fq.rxLevel = rxLevel;

    ffs_freq_meter u_meter (
        .clk   (clk),
        .reset (reset),
        .fq    (fq.meter)
    );

    // Status1 has no write path at all.
    assign wrStatus2 = regWrEn && (regAddr == ffs_pkg::ADDR_STATUS2);
    assign freeSpace = 8'(ffs_pkg::FIFO_DEPTH) - {1'b0, fifoFillCount};

    // CRC result tracks the co-processor: cleared while busy, loaded at finish.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            crcZero_q <= 1'b0;
            crcDone_q <= 1'b0;
        end else begin
            if (crcBusy) begin
                crcZero_q <= 1'b0;
            end else if (crcFinish) begin
                crcZero_q <= crcResultZero;
            end
            if (crcFinish) begin
                crcDone_q <= 1'b1;
            end else if (crcStart) begin
                crcDone_q <= 1'b0;
            end
        end
    end

    // Live conditions are registered once so a status1 read sees one settled cycle.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_q          <= 1'b0;
            timerActive_q  <= 1'b0;
            fieldPresent_q <= 1'b0;
            fieldPrev_q    <= 1'b0;
            nearFull_q     <= 1'b0;
            nearEmpty_q    <= 1'b0;
            modem_q        <= 3'h0;
        end else begin
            irq_q          <= |(commIrqReq & commIrqEnable) | |(divIrqReq & divIrqEnable);
            timerActive_q  <= timerGatedMode ? timerEnabled
                                             : (timerEnabled & timerCounting);
            fieldPresent_q <= fieldDetect;
            fieldPrev_q    <= fieldPresent_q;
            nearFull_q     <= freeSpace <= {2'h0, fifoThreshold};
            nearEmpty_q    <= fifoFillCount <= {1'b0, fifoThreshold};
            modem_q        <= modemState;
        end
    end

    // Host-written controls of status2.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // Reset image is taken bit by bit from the package constant.
            overheatClr_q <= ffs_pkg::STATUS2_RESET[ffs_pkg::S2_OVERHEAT_CLR];
            i2cFast_q     <= ffs_pkg::STATUS2_RESET[ffs_pkg::S2_I2C_FAST];
        end else if (wrStatus2) begin
            overheatClr_q <= regWrData[ffs_pkg::S2_OVERHEAT_CLR];
            i2cFast_q     <= regWrData[ffs_pkg::S2_I2C_FAST];
        end
    end

    // Target flag drops when the external field goes away; set wins.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            target_q <= 1'b0;
            cipher_q <= 1'b0;
        end else begin
            if (targetSelectEvt) begin
                target_q <= 1'b1;
            end else if (fieldPrev_q && !fieldPresent_q) begin
                target_q <= 1'b0;
            end
            if (cipherStartEvt) begin
                cipher_q <= 1'b1;
            end else if (wrStatus2 && !regWrData[ffs_pkg::S2_CIPHER]) begin
                cipher_q <= 1'b0;
            end
        end
    end

    // Overheat error: sensor sets, clear only accepted below the limit.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tempErr_q <= 1'b0;
        end else if (overheatDetect) begin
            tempErr_q <= 1'b1;
        end else if (wrStatus2 && regWrData[ffs_pkg::S2_OVERHEAT_CLR] && tempBelowLimit) begin
            tempErr_q <= 1'b0;
        end
    end

    always_comb begin
        status1 = 8'h00;
        status1[ffs_pkg::S1_FREQ_OK]    = fq.inRange;
        status1[ffs_pkg::S1_CRC_ZERO]   = crcZero_q;
        status1[ffs_pkg::S1_CRC_DONE]   = crcDone_q;
        status1[ffs_pkg::S1_IRQ]        = irq_q;
        status1[ffs_pkg::S1_TIMER]      = timerActive_q;
        status1[ffs_pkg::S1_FIELD]      = fieldPresent_q;
        status1[ffs_pkg::S1_NEAR_FULL]  = nearFull_q;
        status1[ffs_pkg::S1_NEAR_EMPTY] = nearEmpty_q;
    end

    // Bit 5 of status2 stays zero.
    always_comb begin
        status2 = 8'h00;
        status2[ffs_pkg::S2_OVERHEAT_CLR] = overheatClr_q;
        status2[ffs_pkg::S2_I2C_FAST]     = i2cFast_q;
        status2[ffs_pkg::S2_TARGET]       = target_q;
        status2[ffs_pkg::S2_CIPHER]       = cipher_q;
        status2[2:0]                      = modem_q;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData_q <= 8'h00;
        end else if (regRdEn) begin
            unique case (regAddr)
                ffs_pkg::ADDR_STATUS1: rdData_q <= status1;
                ffs_pkg::ADDR_STATUS2: rdData_q <= status2;
                default:               rdData_q <= 8'h00;
            endcase
        end
    end

    assign regRdData          = rdData_q;
    assign tempError          = tempErr_q;
    assign i2cFilterForceFast = i2cFast_q;
    assign targetSelected     = target_q;
    assign cipherSessionOn    = cipher_q;
endmodule

// ---- ffs_status_flags_sva.sv ----
// Purpose: Concurrent checks on the status flag block, seen only through its ports.
// Assumes: Registered status with read data loaded on the edge that takes regRdEn.
// Notes:   Attached by a bind in the testbench top file.
`timescale 1ns/1ps
module ffs_status_flags_sva #(
    parameter int unsigned COMM_IRQ_W = 7,
    parameter int unsigned DIV_IRQ_W  = 5
) (
    // Clock, reset and host port.
    input wire logic                  clk, reset, regWrEn, regRdEn,
    input wire logic [5:0]            regAddr,
    input wire logic [7:0]            regWrData, regRdData,
    // Condition inputs.
    input wire logic                  fieldDetect, crcFinish, timerCounting, timerEnabled,
    input wire logic                  timerGatedMode, overheatDetect, tempBelowLimit,
    input wire logic                  cipherStartEvt,
    input wire logic [COMM_IRQ_W-1:0] commIrqReq, commIrqEnable,
    input wire logic [DIV_IRQ_W-1:0]  divIrqReq, divIrqEnable,
    input wire logic [6:0]            fifoFillCount,
    input wire logic [5:0]            fifoThreshold,
    // Register outputs.
    input wire logic                  tempError, i2cFilterForceFast, targetSelected,
    input wire logic                  cipherSessionOn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire rd1 = regRdEn && regAddr == ffs_pkg::ADDR_STATUS1;
    wire rd2 = regRdEn && regAddr == ffs_pkg::ADDR_STATUS2;
    wire wr2 = regWrEn && regAddr == ffs_pkg::ADDR_STATUS2;
    wire rdX = regRdEn && !rd1 && !rd2;
    property p_field; rd1 && !$past(reset) |=> regRdData[2] == $past(fieldDetect, 2); endproperty
    a_field: assert property (p_field) else $error("field flag wrong");
    property p_near_full; rd1 && !$past(reset) |=> regRdData[1] ==
        ((7'd64 - $past(fifoFillCount, 2)) <= {1'b0, $past(fifoThreshold, 2)}); endproperty
    a_near_full: assert property (p_near_full) else $error("near full wrong");
    property p_near_empty; rd1 && !$past(reset) |=> regRdData[0] ==
        ($past(fifoFillCount, 2) <= {1'b0, $past(fifoThreshold, 2)}); endproperty
    a_near_empty: assert property (p_near_empty) else $error("near empty wrong");
    property p_irq; rd1 && !$past(reset) |=> regRdData[4] == ($past(|(commIrqReq &
        commIrqEnable), 2) || $past(|(divIrqReq & divIrqEnable), 2)); endproperty
    a_irq: assert property (p_irq) else $error("irq bit wrong");
    property p_timer; rd1 && !$past(reset) |=> regRdData[3] == ($past(timerGatedMode, 2) ?
        $past(timerEnabled, 2) : $past(timerEnabled && timerCounting, 2)); endproperty
    a_timer: assert property (p_timer) else $error("timer flag wrong");
    property p_crc_done; rd1 && $past(crcFinish) && !$past(reset) |=> regRdData[5]; endproperty
    a_crc_done: assert property (p_crc_done) else $error("crc done missing");
    property p_s2_view; rd2 |=> !regRdData[5] && regRdData[6] == $past(i2cFilterForceFast)
        && regRdData[4] == $past(targetSelected) && regRdData[3] == $past(cipherSessionOn);
    endproperty
    a_s2_view: assert property (p_s2_view) else $error("status2 view wrong");
    property p_unmapped; rdX |=> regRdData == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_i2c_write; wr2 |=> i2cFilterForceFast == $past(regWrData[6]); endproperty
    a_i2c_write: assert property (p_i2c_write) else $error("i2c bit not stored");
    property p_cipher_clear; wr2 && !regWrData[3] && !cipherStartEvt |=> !cipherSessionOn;
    endproperty
    a_cipher_clear: assert property (p_cipher_clear) else $error("cipher not cleared");
    property p_temp_hold; wr2 && tempError && !tempBelowLimit |=> tempError; endproperty
    a_temp_hold: assert property (p_temp_hold) else $error("hot error cleared");
    property p_temp_clear; wr2 && regWrData[7] && tempBelowLimit && !overheatDetect
        |=> !tempError; endproperty
    a_temp_clear: assert property (p_temp_clear) else $error("temp error kept");
endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the status flag block.
// Assumes: Inputs change at the falling edge; reads return one cycle after the strobe.
// Notes:   Expected values come from a small behavioural model of the flags.
`timescale 1ns/1ps
module tb_top;
    logic       clk = 0, reset = 1, regWrEn = 0, regRdEn = 0, rxLevel = 0, fieldDetect = 0;
    logic       crcStart = 0, crcBusy = 0, crcFinish = 0, crcResultZero = 0;
    logic       timerCounting = 0, timerEnabled = 0, timerGatedMode = 0, overheatDetect = 0;
    logic       tempBelowLimit = 0, targetSelectEvt = 0, cipherStartEvt = 0;
    logic [5:0] regAddr = 6'h00, fifoThreshold = 6'h00;
    logic [7:0] regWrData = 8'h00, regRdData;
    logic [6:0] commIrqReq = 7'h00, commIrqEnable = 7'h00, fifoFillCount = 7'h00;
    logic [4:0] divIrqReq = 5'h00, divIrqEnable = 5'h00;
    logic [2:0] modemState = 3'h0;
    logic       tempError, i2cFilterForceFast, targetSelected, cipherSessionOn;
    int         err_count = 0, total_checks = 0, seed = 1865, rxPer = 0, rxCnt = 0;
    int         freqM = 0, crcZeroM = 0, crcDoneM = 0, fills[4] = '{60, 59, 4, 5};
    always #2.5 clk = ~clk;
    ffs_status_flags uut (.clk, .reset, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
        .rxLevel, .fieldDetect, .crcStart, .crcBusy, .crcFinish, .crcResultZero, .commIrqReq,
        .commIrqEnable, .divIrqReq, .divIrqEnable, .timerCounting, .timerEnabled,
        .timerGatedMode, .fifoFillCount, .fifoThreshold, .overheatDetect, .tempBelowLimit,
        .targetSelectEvt, .cipherStartEvt, .modemState, .tempError, .i2cFilterForceFast,
        .targetSelected, .cipherSessionOn);
    // Receive carrier with a period of rxPer cycles; zero keeps the line still.
    always @(negedge clk) begin
        rxCnt = (rxPer == 0) ? 0 : (rxCnt + 1) % rxPer;
        rxLevel <= (rxPer != 0) && (rxCnt < rxPer / 2);
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        cyc(1);
        regWrEn = 0;
        // One idle cycle keeps back-to-back strobes apart.
        cyc(1);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        regAddr = a;
        regRdEn = 1;
        cyc(1);
        regRdEn = 0;
        cyc(1);
        chk(regRdData, exp);
    endtask
    function automatic logic [7:0] s1();
        int   ff  = fifoFillCount;
        int   th  = fifoThreshold;
        logic irq = |(commIrqReq & commIrqEnable) || |(divIrqReq & divIrqEnable);
        logic tmr = timerGatedMode ? timerEnabled : timerEnabled && timerCounting;
        return {freqM[0], crcZeroM[0], crcDoneM[0], irq, tmr, fieldDetect, 64 - ff <= th, ff <= th};
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
    initial begin
        cyc(21);
        reset = 0;
        rd(ffs_pkg::ADDR_STATUS2, ffs_pkg::STATUS2_RESET);
        rd(ffs_pkg::ADDR_STATUS1, s1());
        for (int i = 0; i < 40; i++) begin
            {fieldDetect, timerCounting, timerEnabled, timerGatedMode, commIrqReq,
                commIrqEnable, divIrqReq, divIrqEnable} = 28'($random(seed));
            fifoFillCount = 7'($unsigned($random(seed)) % 65);
            fifoThreshold = 6'($random(seed));
            if (i < 4) begin
                fifoFillCount = 7'(fills[i]);
                fifoThreshold = 6'h04;
            end
            cyc(2);
            rd(ffs_pkg::ADDR_STATUS1, s1());
            wr(ffs_pkg::ADDR_STATUS1, 8'hFF);
            rd(ffs_pkg::ADDR_STATUS1, s1());
        end
        $display("test random status1 done");
        rd(6'h3F, 8'h00);
        wr(ffs_pkg::ADDR_STATUS2, 8'hFF);
        for (int m = 0; m < 7; m++) begin
            modemState = 3'(m);
            cyc(2);
            rd(ffs_pkg::ADDR_STATUS2, {5'h18, 3'(m)});
        end
        wr(ffs_pkg::ADDR_STATUS2, 8'h00);
        chk({7'h00, i2cFilterForceFast}, 8'h00);
        fieldDetect = 1;
        cyc(2);
        pulse(targetSelectEvt);
        chk({7'h00, targetSelected}, 8'h01);
        fieldDetect = 0;
        cyc(3);
        chk({7'h00, targetSelected}, 8'h00);
        pulse(cipherStartEvt);
        chk({7'h00, cipherSessionOn}, 8'h01);
        wr(ffs_pkg::ADDR_STATUS2, 8'h00);
        chk({7'h00, cipherSessionOn}, 8'h00);
        pulse(overheatDetect);
        chk({7'h00, tempError}, 8'h01);
        wr(ffs_pkg::ADDR_STATUS2, 8'h80);
        chk({7'h00, tempError}, 8'h01);
        tempBelowLimit = 1;
        wr(ffs_pkg::ADDR_STATUS2, 8'h80);
        chk({7'h00, tempError}, 8'h00);
        // Mid-run reset must bring status2 and its outputs back to zero.
        wr(ffs_pkg::ADDR_STATUS2, 8'hC0);
        reset = 1;
        cyc(3);
        chk({4'h0, tempError, i2cFilterForceFast, targetSelected, cipherSessionOn}, 8'h00);
        reset = 0;
        rd(ffs_pkg::ADDR_STATUS2, ffs_pkg::STATUS2_RESET);
        $display("test status2 done");
        for (int k = 0; k < 2; k++) begin
            pulse(crcStart);
            crcDoneM = 0;
            crcZeroM = 0;
            crcBusy = 1;
            cyc(3);
            rd(ffs_pkg::ADDR_STATUS1, s1());
            crcBusy = 0;
            crcResultZero = k[0];
            pulse(crcFinish);
            crcDoneM = 1;
            crcZeroM = k;
            rd(ffs_pkg::ADDR_STATUS1, s1());
        end
        $display("test crc done");
        rxPer = 15;
        cyc(4100);
        freqM = 1;
        rd(ffs_pkg::ADDR_STATUS1, s1());
        rxPer = 10;
        cyc(4100);
        freqM = 0;
        rd(ffs_pkg::ADDR_STATUS1, s1());
        rxPer = 0;
        $display("test frequency done");
        finish_test();
    end
endmodule
bind ffs_status_flags ffs_status_flags_sva #(.COMM_IRQ_W(COMM_IRQ_W), .DIV_IRQ_W(DIV_IRQ_W))
    u_sva (.clk, .reset, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .fieldDetect,
    .crcFinish, .timerCounting, .timerEnabled, .timerGatedMode, .overheatDetect,
    .tempBelowLimit, .cipherStartEvt, .commIrqReq, .commIrqEnable, .divIrqReq, .divIrqEnable,
    .fifoFillCount, .fifoThreshold, .tempError, .i2cFilterForceFast, .targetSelected,
    .cipherSessionOn);
